/* File: src/acs_sequencer.sv */
// conversion sequencer: runs slot passes, raises event flags, emits results
// assumes a converter handshake (req/done) and a result FIFO that accepts every push
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
// What this block does
// - kind 0: software start bit only
// - kind 1: selected hardware trigger starts
// - repeat 0: one pass then stop
// - repeat 1: passes repeat while start set
// - slot count holds channels minus one
// - slots converted in slot order, channel id taken per slot
// - nonzero exponent: two-power conversions averaged
// - software mode: start begins immediately
// - single pass sets sequence and conversion done
// - results pushed to result FIFO
// - hardware mode: start only arms
// - hardware start sets sequence-began flag
// - hardware trigger is level sensitive only before any pass has started
// - later hardware starts need rising edge
// - hardware single pass rearms while start set, next trigger edge restarts
// - continuous: sequence done every pass
// - continuous: idle restart delay then repeat
// - start cleared during a pass: finish pass, conversion done; cleared in restart delay: back to idle, no flag
// - source index maps timers, pins, temperature
// - start begins a sequence on zero-to-one change only
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int SLOTS  = `ACS_SLOTS,
  parameter int CHAN_W = `ACS_CHAN_W
) (
  input  wire logic                            clock_in,
  input  wire logic                            nrst_in,
  input  wire acs_config_t                     config_in,
  input  wire logic                            start_in,
  input  wire logic [SLOTS*CHAN_W-1:0]         slot_channel_id_in,
  input  wire logic [3:0]                      timer_trig_in,
  input  wire logic [1:0]                      pin_trig_in,
  input  wire logic                            temp_ready_in,
  input  wire logic                            sample_tick_in,
  input  wire acs_flags_t                      flag_clear_in,
  output var  acs_flags_t                      event_flag_register_out,
  output logic                                 conv_req_out,
  output logic [CHAN_W-1:0]                    conv_channel_out,
  input  wire logic                            conv_done_in,
  input  wire logic [`ACS_DATA_W-1:0]          conv_data_in,
  output logic                                 result_valid_out,
  output var  acs_result_t                     result_out,
  output logic                                 busy_out
);
  localparam int SUM_W = `ACS_DATA_W + 8;

  acs_state_t                 state;
  logic                       start_q;
  logic                       start_rise;
  logic [`ACS_SLOT_W-1:0]     slot;
  logic [7:0]                 rep;
  logic [SUM_W-1:0]           acc;
  logic [`ACS_RESTART_W-1:0]  delay_cnt;
  logic                       trig_raw;
  logic                       trig_meta;
  logic                       trig_sync;
  logic                       trig_prev;
  logic                       trig_rise;
  logic                       sw_seen;
  logic                       trig_go;
  logic [7:0]                 reps_total;
  logic [SUM_W-1:0]           sum_now;
  logic                       pass_end;
  logic                       rep_end;
  logic [CHAN_W-1:0]          chan_sel [SLOTS];

  genvar gi;
  generate
    for (gi = 0; gi < SLOTS; gi++) begin : g_slot
      assign chan_sel[gi] = slot_channel_id_in[gi*CHAN_W +: CHAN_W];
    end
  endgenerate

  always_comb begin
    unique case (config_in.trigger_source)
      3'h0, 3'h1, 3'h2, 3'h3: trig_raw = timer_trig_in[config_in.trigger_source[1:0]];
      `ACS_TRIG_RESERVED:     trig_raw = 1'b0;
      3'h5:                   trig_raw = pin_trig_in[0];
      3'h6:                   trig_raw = pin_trig_in[1];
      `ACS_TRIG_TEMP:         trig_raw = temp_ready_in;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      trig_meta <= trig_raw;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end
  assign trig_rise = trig_sync & ~trig_prev;
  // level start before any software or hardware start, edge after
  assign trig_go = sw_seen ? trig_rise : trig_sync;

  always_ff @(posedge clock_in) begin
    if (!nrst_in) start_q <= 1'b0;
    else start_q <= start_in;
  end
  assign start_rise = start_in & ~start_q;

  assign reps_total = 8'(1) << config_in.average_exp;
  assign sum_now    = acc + SUM_W'(conv_data_in);
  assign rep_end    = (rep == reps_total - 8'(1));
  assign pass_end   = (slot == config_in.slot_count);

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      state     <= ACS_IDLE;
      slot      <= '0;
      rep       <= '0;
      acc       <= '0;
      delay_cnt <= '0;
    end else begin
      unique case (state)
        ACS_IDLE: begin
          slot <= '0;
          rep  <= '0;
          acc  <= '0;
          if (start_rise) begin
            if (config_in.trigger_kind == `ACS_KIND_SW) state <= ACS_CONVERT;
            else state <= ACS_ARMED;
          end
        end
        ACS_ARMED: begin
          if (!start_in) state <= ACS_IDLE;
          else if (trig_go) state <= ACS_CONVERT;
        end
        ACS_CONVERT: state <= ACS_WAIT;
        ACS_WAIT: begin
          if (conv_done_in) begin
            if (!rep_end) begin
              rep   <= rep + 8'(1);
              acc   <= sum_now;
              state <= ACS_CONVERT;
            end else begin
              rep <= '0;
              acc <= '0;
              if (!pass_end) begin
                slot  <= slot + `ACS_SLOT_W'(1);
                state <= ACS_CONVERT;
              end else begin
                slot <= '0;
                if (config_in.repeat_select == `ACS_REPEAT_CONT && start_in) begin
                  delay_cnt <= config_in.restart_delay;
                  state     <= ACS_RESTART;
                end else if (config_in.trigger_kind == `ACS_KIND_HW && start_in &&
                             config_in.repeat_select == `ACS_REPEAT_ONCE) begin
                  // rearm, wait for a fresh trigger edge
                  state <= ACS_ARMED;
                end else begin
                  state <= ACS_IDLE;
                end
              end
            end
          end
        end
        ACS_RESTART: begin
          // count sample ticks down to zero
          if (!start_in) state <= ACS_IDLE;
          else if (delay_cnt == '0) state <= ACS_CONVERT;
          else if (sample_tick_in) delay_cnt <= delay_cnt - `ACS_RESTART_W'(1);
        end
      endcase
    end
  end

  // first pass, software or hardware, disables level triggering
  always_ff @(posedge clock_in) begin
    if (!nrst_in) sw_seen <= 1'b0;
    else if (state == ACS_IDLE && start_rise && config_in.trigger_kind == `ACS_KIND_SW)
      sw_seen <= 1'b1;
    else if (state == ACS_ARMED && trig_go)
      sw_seen <= 1'b1;
  end

  logic ev_start;
  logic ev_seq;
  logic ev_conv;
  assign ev_start = (state == ACS_ARMED) && start_in && trig_go;
  assign ev_seq   = (state == ACS_WAIT) && conv_done_in && rep_end && pass_end;
  assign ev_conv  = ev_seq && !(config_in.repeat_select == `ACS_REPEAT_CONT && start_in);

  // write-one clears, set wins over clear
  always_ff @(posedge clock_in) begin
    if (!nrst_in) event_flag_register_out <= '0;
    else begin
      event_flag_register_out.seq_started <= ev_start |
        (event_flag_register_out.seq_started & ~flag_clear_in.seq_started);
      event_flag_register_out.seq_done <= ev_seq |
        (event_flag_register_out.seq_done & ~flag_clear_in.seq_done);
      event_flag_register_out.conv_done <= ev_conv |
        (event_flag_register_out.conv_done & ~flag_clear_in.conv_done);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      result_valid_out <= 1'b0;
      result_out       <= '0;
    end else begin
      result_valid_out <= (state == ACS_WAIT) && conv_done_in && rep_end;
      if ((state == ACS_WAIT) && conv_done_in && rep_end) begin
        result_out.channel <= chan_sel[slot];
        result_out.data    <= `ACS_DATA_W'(sum_now >> config_in.average_exp);
      end
    end
  end

  assign conv_req_out     = (state == ACS_CONVERT);
  assign conv_channel_out = chan_sel[slot];
  assign busy_out         = (state == ACS_CONVERT) || (state == ACS_WAIT);

  a_sw_start: assert property (@(posedge clock_in) disable iff (!nrst_in)
    state == ACS_IDLE && start_rise && config_in.trigger_kind == `ACS_KIND_SW
      |=> conv_req_out) else $error("software start did not convert");
  a_hw_arm: assert property (@(posedge clock_in) disable iff (!nrst_in)
    state == ACS_IDLE && start_rise && config_in.trigger_kind == `ACS_KIND_HW
      |=> state == ACS_ARMED) else $error("hardware start did not arm");
  a_began_flag: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ev_start |=> event_flag_register_out.seq_started) else $error("began flag missing");
  a_seq_flag: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ev_seq |=> event_flag_register_out.seq_done) else $error("sequence done flag missing");
  a_single_stop: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ev_seq && config_in.repeat_select == `ACS_REPEAT_ONCE
      |=> event_flag_register_out.conv_done && !conv_req_out)
    else $error("single pass did not stop");
  a_cont_delay: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ev_seq && config_in.repeat_select == `ACS_REPEAT_CONT && start_in
      |=> state == ACS_RESTART) else $error("continuous pass did not idle");
  a_tick_count: assert property (@(posedge clock_in) disable iff (!nrst_in)
    state == ACS_RESTART && start_in && delay_cnt != '0 && sample_tick_in
      |=> delay_cnt == $past(delay_cnt) - `ACS_RESTART_W'(1))
    else $error("restart delay did not count");
  a_result_push: assert property (@(posedge clock_in) disable iff (!nrst_in)
    state == ACS_WAIT && conv_done_in && rep_end |=> result_valid_out)
    else $error("result not pushed");
  a_sw_ignore_trig: assert property (@(posedge clock_in) disable iff (!nrst_in)
    config_in.trigger_kind == `ACS_KIND_SW && state == ACS_IDLE && !start_rise
      |=> state == ACS_IDLE) else $error("started without software");
  c_hw_start: cover property (@(posedge clock_in) ev_start);
  c_cont_restart: cover property (@(posedge clock_in) state == ACS_RESTART ##1 conv_req_out);
  c_avg_pass: cover property (@(posedge clock_in) ev_seq && config_in.average_exp != '0);
endmodule // acs_sequencer
`default_nettype wire

/* File: src/acs_params.svh */
// constants for the conversion sequencer: slot count, field widths, encodings
// assumes inclusion by bare name from the package and design files
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
`define ACS_SLOTS          16
`define ACS_SLOT_W         4
`define ACS_CHAN_W         5
`define ACS_AVG_W          3
`define ACS_RESTART_W      16
`define ACS_TRIG_SEL_W     3
`define ACS_DATA_W         12
`define ACS_TRIG_RESERVED  3'h4
`define ACS_TRIG_TEMP      3'h7
`define ACS_KIND_SW        1'h0
`define ACS_KIND_HW        1'h1
`define ACS_REPEAT_ONCE    1'h0
`define ACS_REPEAT_CONT    1'h1
`endif

/* File: src/acs_pkg.sv */
// types for the conversion sequencer
// assumes acs_params.svh is on the include path
`include "acs_params.svh"
package acs_pkg;
  typedef struct packed {
    logic                        trigger_kind;
    logic                        repeat_select;
    logic [`ACS_TRIG_SEL_W-1:0]  trigger_source;
    logic [`ACS_SLOT_W-1:0]      slot_count;
    logic [`ACS_AVG_W-1:0]       average_exp;
    logic [`ACS_RESTART_W-1:0]   restart_delay;
  } acs_config_t;
  typedef struct packed {
    logic seq_started;
    logic seq_done;
    logic conv_done;
  } acs_flags_t;
  typedef struct packed {
    logic [`ACS_CHAN_W-1:0] channel;
    logic [`ACS_DATA_W-1:0] data;
  } acs_result_t;
  typedef enum logic [2:0] {ACS_IDLE, ACS_ARMED, ACS_CONVERT, ACS_WAIT, ACS_RESTART} acs_state_t;
endpackage

/* File: tb/acs_conv_model.sv */
// converter stand-in: answers each request promptly or slowly, in turn
// assumes one request outstanding, requests sampled on rising edges
`timescale 1ns/1ps
`default_nettype none
module acs_conv_model (
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic        req_in,
  output logic             done_out,
  output logic [11:0]      data_out
);
  int   wait_left = 0;
  logic slow      = 1'b0;
  initial begin
    done_out = 1'b0;
    data_out = 12'h5A3;
  end
  // data word moves every cycle so a stale sample never matches by luck
  always @(posedge clock_in) begin
    data_out <= {data_out[10:0], ~(data_out[11] ^ data_out[6])};
    done_out <= (wait_left == 1);
    if (!nrst_in) begin
      wait_left <= 0;
    end else if (req_in) begin
      wait_left <= slow ? 6 : 1;
      slow      <= ~slow;
    end else if (wait_left > 0) begin
      wait_left <= wait_left - 1;
    end
  end
endmodule // acs_conv_model
`default_nettype wire

/* File: tb/tb_adc_conversion_sequencer.sv */
// self-checking bench: queue model of slots and averages, scenarios per mode
// assumes acs_sequencer with default parameters and the converter stand-in
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
module tb_adc_conversion_sequencer;
  import acs_pkg::*;
  logic         clock_in = 1'b0;
  logic         nrst_in = 1'b0;
  logic         start_in = 1'b0;
  logic         tick_in = 1'b0;
  logic         temp_in = 1'b0;
  logic [3:0]   timer_in = 4'h0;
  logic [1:0]   pin_in = 2'h0;
  logic [79:0]  ids = '0;
  acs_config_t  cfg = '0;
  acs_flags_t   clr = '0;
  acs_flags_t   flags;
  acs_result_t  res;
  logic         req, done, valid, busy;
  logic [4:0]   ch;
  logic [11:0]  data;
  acs_result_t  exp_q[$];
  integer       seed = 32'h761B;
  int           fail_count = 0, comparisons = 0, cycles = 0;
  int           slot = 0, nconv = 0, sum = 0, reqs = 0, results = 0;

  acs_sequencer dut (.clock_in(clock_in), .nrst_in(nrst_in), .config_in(cfg),
    .start_in(start_in), .slot_channel_id_in(ids), .timer_trig_in(timer_in),
    .pin_trig_in(pin_in), .temp_ready_in(temp_in), .sample_tick_in(tick_in),
    .flag_clear_in(clr), .event_flag_register_out(flags), .conv_req_out(req),
    .conv_channel_out(ch), .conv_done_in(done), .conv_data_in(data),
    .result_valid_out(valid), .result_out(res), .busy_out(busy));
  acs_conv_model conv (.clock_in(clock_in), .nrst_in(nrst_in), .req_in(req),
    .done_out(done), .data_out(data));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // source 4 drives every source at once
  task automatic set_trig(input int src, input logic lvl);
    if (src < 4) timer_in[src] <= lvl;
    else if (src == 5 || src == 6) pin_in[src-5] <= lvl;
    else if (src == 7) temp_in <= lvl;
    else begin
      timer_in <= {4{lvl}};
      pin_in <= {2{lvl}};
      temp_in <= lvl;
    end
  endtask
  task automatic wait_flag(input logic [2:0] mask);
    int n;
    n = 0;
    while ((flags & mask) !== mask && n < 3000) begin
      @(negedge clock_in);
      n++;
    end
    @(posedge clock_in);
    check("flag wait", 32'(n < 3000), 32'h1);
  endtask
  task automatic run(input logic kind, input logic rep, input int src, input logic [3:0] slots,
                     input logic [2:0] avg, input logic [15:0] delay);
    clr <= '1;
    cfg <= {kind, rep, 3'(src), slots, avg, delay};
    ids <= 80'({$random(seed), $random(seed), $random(seed)});
    start_in <= 1'b0;
    tick(1);
    clr <= '0;
    tick(1);
    start_in <= 1'b1;
    tick(1);
  endtask

  initial forever #5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles++;
    tick_in <= (cycles % 4 == 0);
    if (cycles == 60000) begin
      fail_count++;
      close_out();
    end
  end
  always @(negedge clock_in) begin
    if (nrst_in !== 1'b1) begin
      slot = 0;
      nconv = 0;
      sum = 0;
    end else begin
      if (req === 1'b1) begin
        reqs++;
        check("channel", 32'(ch), 32'(ids[slot*5+:5]));
      end
      if (done === 1'b1) begin
        sum += data;
        nconv++;
      end
      if (nconv == (1 << cfg.average_exp)) begin
        exp_q.push_back({ids[slot*5+:5], 12'(sum >> cfg.average_exp)});
        sum = 0;
        nconv = 0;
        slot = (slot == cfg.slot_count) ? 0 : slot + 1;
      end
      if (valid === 1'b1) begin
        results++;
        check("result", 32'(res), exp_q.size() ? 32'(exp_q.pop_front()) : '1);
      end
    end
  end

  initial begin
    int r, s, gap;
    tick(12);
    nrst_in <= 1'b1;
    set_trig(0, 1'b1);
    tick(6);
    run(`ACS_KIND_HW, `ACS_REPEAT_ONCE, 0, 4'h1, 3'h0, 16'h0);
    wait_flag(3'h7);
    r = reqs;
    tick(30);
    check("held trigger", 32'(reqs), 32'(r));
    set_trig(0, 1'b0);
    for (int k = 0; k < 3; k++) begin
      r = results;
      s = reqs;
      run(`ACS_KIND_SW, `ACS_REPEAT_ONCE, 0, (k == 0) ? 4'h4 : 4'(k * 15 - 15), 3'(k), 16'h0);
      tick(1);
      check("prompt start", 32'(reqs - s), 32'h1);
      check("busy converting", 32'(busy), 32'h1);
      wait_flag(3'h3);
      tick(2);
      check("slot count", 32'(results - r), 32'(cfg.slot_count) + 1);
      r = reqs;
      set_trig(4, 1'b1);
      tick(40);
      check("no restart", 32'(reqs), 32'(r));
      check("idle busy", 32'(busy), 32'h0);
      set_trig(4, 1'b0);
    end
    run(`ACS_KIND_SW, `ACS_REPEAT_CONT, 0, 4'h2, 3'h0, 16'h3);
    wait_flag(3'h2);
    check("pass one", 32'(flags.conv_done), 32'h0);
    r = reqs;
    gap = 0;
    while (reqs == r && gap < 200) begin
      @(negedge clock_in);
      gap++;
    end
    @(posedge clock_in);
    check("restart gap", 32'(gap >= 8 && gap <= 17), 32'h1);
    clr <= '1;
    start_in <= 1'b0;
    tick(1);
    clr <= '0;
    wait_flag(3'h3);
    r = reqs;
    tick(40);
    check("stopped", 32'(reqs), 32'(r));
    check("stopped busy", 32'(busy), 32'h0);
    // software passes above precede hardware triggering
    for (int i = 0; i < 8; i++) begin
      s = (i == 7) ? 4 : ((i < 4) ? i : i + 1);
      run(`ACS_KIND_HW, `ACS_REPEAT_ONCE, s, 4'(i), 3'h0, 16'h0);
      r = reqs;
      tick(20);
      check("armed only", 32'(reqs), 32'(r));
      set_trig(s, 1'b1);
      if (s == 4) begin
        tick(40);
        check("reserved", 32'(reqs), 32'(r));
      end else begin
        wait_flag(3'h7);
        clr <= '1;
        set_trig(s, 1'b0);
        tick(1);
        clr <= '0;
        tick(4);
        set_trig(s, 1'b1);
        wait_flag(3'h7);
      end
      start_in <= 1'b0;
      set_trig(4, 1'b0);
      tick(2);
    end
    // hardware continuous: one trigger edge, then passes repeat until start drops
    run(`ACS_KIND_HW, `ACS_REPEAT_CONT, 5, 4'h1, 3'h1, 16'h2);
    set_trig(5, 1'b1);
    wait_flag(3'h6);
    check("hw cont pass", 32'(flags.conv_done), 32'h0);
    r = reqs;
    gap = 0;
    while (reqs == r && gap < 200) begin
      @(negedge clock_in);
      gap++;
    end
    @(posedge clock_in);
    check("hw cont repeat", 32'(gap < 200), 32'h1);
    clr <= '1;
    start_in <= 1'b0;
    tick(1);
    clr <= '0;
    wait_flag(3'h3);
    r = reqs;
    tick(40);
    check("hw cont stopped", 32'(reqs), 32'(r));
    set_trig(5, 1'b0);
    tick(2);
    close_out();
  end
endmodule // tb_adc_conversion_sequencer
`default_nettype wire
